// *** bench/dci_channel_test.sv ***
// self-checking bench: user commands in, dram pins checked through the model
`timescale 1ns/1ps
`include "dci_cfg.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module dci_channel_test;
  logic ref_clk = 1'b0;
  logic mem_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic cmd_rank = 1'b0;
  logic [14:0] cmd_row = 15'h7ABC;
  logic [63:0] wr_data = 64'h0;
  logic [7:0] wr_mask = 8'h00;
  logic [7:0] wr_ecc = 8'h00;
  logic cfg_lp_mode = 1'b0;
  logic cfg_ecc_en = 1'b0;
  logic [1:0] cfg_geometry = 2'h0;
  logic [3:0] cfg_rd_lat = 4'h5;
  logic [3:0] cfg_wr_lat = 4'h3;
  logic cfg_clk_gate_en = 1'b0;
  logic cfg_slow_pd = 1'b0;
  logic [63:0] rd_word = 64'h0;
  logic [7:0] rd_chk = 8'h00;
  logic [2:0] rd_delay = 3'h0;
  logic mute = 1'b0;
  logic cmd_ready, rd_valid, rd_timeout, ch1_enable, ras_n, cas_n, we_n, cmd_oe, dq_oe;
  logic memory_reset_out_n, ecc_strobe_true_in, ecc_strobe_complement_in;
  logic [63:0] rd_data, dq_in, dq_out, seen_wdata;
  logic [7:0] rd_ecc, dm, dqs_p_in, dqs_n_in, dqs_p_out, ecc_check_byte_in, ecc_check_byte_out;
  logic [7:0] seen_wmask, seen_wchk;
  logic [1:0] ck_p, cs_n, odt, seen_cs_n, seen_odt;
  logic [3:0] cke;
  logic [15:0] ma, seen_ma;
  logic [9:0] lp_command_address_bus, seen_lp;
  logic [2:0] seen_enc;
  logic [4:0] seen_gap;
  int failures = 0;
  int samples_checked = 0;
  int rd_pulses = 0;
  int oe_cycles = 0;
  dci_pkg::dci_cmd_t codes [4] = '{dci_pkg::DCI_ACT, dci_pkg::DCI_PRE, dci_pkg::DCI_REF,
    dci_pkg::DCI_MRS};
  logic [2:0] encs [4] = '{`DCI_ENC_ACT, `DCI_ENC_PRE, `DCI_ENC_REF, `DCI_ENC_MRS};

  always #5 ref_clk = ~ref_clk;
  always #6 mem_clk = ~mem_clk;

  dci_channel dut (
    .ref_clk, .rst_n, .mem_clk, .cmd_valid, .cmd_ready, .cmd_code, .cmd_rank, .cmd_bank(3'h5),
    .cmd_row, .cmd_col(10'h3FF), .wr_data, .wr_mask, .wr_ecc, .wr_ecc_mask(1'b0), .cfg_lp_mode,
    .cfg_ecc_en, .cfg_geometry, .cfg_rd_lat, .cfg_wr_lat, .cfg_clk_gate_en, .cfg_slow_pd,
    .rd_valid, .rd_data, .rd_ecc, .rd_timeout, .ch1_enable, .ck_p, .ck_n(), .cs_n, .cke, .ras_n,
    .cas_n, .we_n, .ma, .ba(), .lp_command_address_bus, .cmd_oe, .odt, .memory_reset_out_n,
    .dq_in, .dq_out, .dq_oe, .dm, .dqs_p_in, .dqs_n_in, .dqs_p_out, .dqs_n_out(), .dqs_oe(),
    .ecc_check_byte_in, .ecc_check_byte_out, .ecc_check_byte_oe(), .ecc_check_byte_mask(),
    .ecc_strobe_true_in, .ecc_strobe_complement_in, .ecc_strobe_true_out(),
    .ecc_strobe_complement_out(), .ecc_strobe_oe()
  );

  dci_dram_model model (
    .mem_clk, .cmd_oe, .cs_n, .ras_n, .cas_n, .we_n, .ma, .lp_command_address_bus, .odt,
    .dq_out, .dq_oe, .dm, .dqs_p_out, .ecc_check_byte_out, .rd_word, .rd_chk,
    .rd_lat(cfg_rd_lat), .rd_delay, .mute, .dq_in, .dqs_p_in, .dqs_n_in, .ecc_check_byte_in,
    .ecc_strobe_true_in, .ecc_strobe_complement_in, .seen_enc, .seen_cs_n, .seen_ma, .seen_lp,
    .seen_wdata, .seen_wmask, .seen_wchk, .seen_odt, .seen_gap
  );

  // tallies of read answers and driven command cycles; the clocks never share a rising edge
  always @(posedge ref_clk)
    if (rd_valid === 1'b1)
      rd_pulses++;
  always @(posedge mem_clk)
    if (cmd_oe === 1'b1)
      oe_cycles++;

  task automatic wrap_up();
    begin
      if (failures == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // one request per call: held for the taking edge, then wait for idle under a bound
  task automatic do_cmd(input logic [3:0] code, input logic rank);
    int n;
    begin
      cmd_code <= code;
      cmd_rank <= rank;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 300)
      begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 300)
      begin
        failures++;
        $display("[ERR] %0t command never completed", $time);
        wrap_up();
      end
    end
  endtask

  // compares two consecutive link-clock samples of the rank clocks
  task automatic ck_check(input logic run);
    logic [1:0] a;
    begin
      @(posedge mem_clk);
      a = ck_p;
      @(posedge mem_clk);
      `CHK(ck_p !== a, run)
      @(posedge ref_clk);
    end
  endtask

  initial
  begin
    int o;
    repeat (12) @(posedge ref_clk);
    `CHK(cs_n, 2'h3)
    `CHK(cke, 4'h0)
    `CHK(cmd_oe, 1'b0)
    rst_n <= 1'b1;
    @(posedge ref_clk);
    do_cmd(dci_pkg::DCI_RSTX, 1'b0);
    `CHK(memory_reset_out_n, 1'b1)
    do_cmd(dci_pkg::DCI_PDX, 1'b0);
    `CHK(cke, 4'hF)
    ck_check(1'b1);
    // plain commands on alternating ranks, each driven for a single cycle
    for (int i = 0; i < 4; i++)
    begin
      o = oe_cycles;
      do_cmd(codes[i], i[0]);
      `CHK(seen_enc, encs[i])
      `CHK(seen_cs_n, ~(2'h1 << i[0]))
      `CHK(oe_cycles - o, 1)
      if (i == 0) `CHK(seen_ma, 16'h3ABC)
    end
    // writes at both latency limits, second on the other rank
    for (int i = 0; i < 2; i++)
    begin
      cfg_wr_lat <= i[0] ? 4'h8 : 4'h3;
      wr_data <= 64'h0123_4567_89AB_CDEF ^ {64{i[0]}};
      wr_mask <= 8'h5A;
      do_cmd(dci_pkg::DCI_WR, i[0]);
      `CHK(seen_wdata, 64'h0123_4567_89AB_CDEF ^ {64{i[0]}})
      `CHK(seen_wmask, 8'h5A)
      `CHK(seen_odt, 2'h1 << i[0])
      `CHK(odt, 2'h0)
      `CHK(seen_gap, i[0] ? 5'h8 : 5'h3)
      `CHK(seen_ma, 16'h03FF)
    end
    // reads at both latency limits, answered promptly and late
    for (int i = 0; i < 4; i++)
    begin
      cfg_rd_lat <= i[1] ? 4'hD : 4'h5;
      rd_delay <= i[0] ? 3'h3 : 3'h0;
      rd_word <= {16{i[3:0] + 4'h9}};
      o = rd_pulses;
      do_cmd(dci_pkg::DCI_RD, 1'b0);
      repeat (2) @(posedge ref_clk);
      `CHK(rd_data, {16{i[3:0] + 4'h9}})
      `CHK(rd_timeout, 1'b0)
      `CHK(rd_pulses - o, 1)
    end
    mute <= 1'b1;
    do_cmd(dci_pkg::DCI_RD, 1'b0);
    `CHK(rd_timeout, 1'b1)
    mute <= 1'b0;
    // check byte rides on the second channel's pins
    cfg_ecc_en <= 1'b1;
    wr_ecc <= 8'hC3;
    rd_chk <= 8'h96;
    do_cmd(dci_pkg::DCI_WR, 1'b0);
    `CHK(ch1_enable, 1'b0)
    `CHK(seen_wchk, 8'hC3)
    do_cmd(dci_pkg::DCI_RD, 1'b0);
    `CHK(rd_ecc, 8'h96)
    // low-power mode over every density
    cfg_lp_mode <= 1'b1;
    cmd_row <= 15'h7FFF;
    for (int g = 0; g < 3; g++)
    begin
      cfg_geometry <= g[1:0];
      do_cmd(dci_pkg::DCI_ACT, g[0]);
      `CHK(ch1_enable, 1'b1)
      `CHK(seen_ma, g[1] ? 16'h7FFF : 16'h3FFF)
      `CHK(seen_lp, {3'h7, 3'h3, 4'h1})
      `CHK(seen_enc, 3'h7)
      `CHK(seen_cs_n, ~(2'h1 << g[0]))
      do_cmd(dci_pkg::DCI_RD, 1'b0);
      `CHK(seen_ma, g[1:0] == 2'h0 ? 16'h01FF : 16'h03FF)
      `CHK(rd_data, 64'hCCCC_CCCC_CCCC_CCCC)
    end
    // power states: gated clock in self-refresh, slow power-down
    cfg_clk_gate_en <= 1'b1;
    do_cmd(dci_pkg::DCI_SRE, 1'b0);
    `CHK(cke, 4'h0)
    ck_check(1'b0);
    do_cmd(dci_pkg::DCI_SRX, 1'b0);
    `CHK(cke, 4'h5)
    ck_check(1'b1);
    cfg_slow_pd <= 1'b1;
    do_cmd(dci_pkg::DCI_PDE, 1'b0);
    ck_check(1'b0);
    do_cmd(dci_pkg::DCI_PDX, 1'b0);
    `CHK(cke, 4'h5)
    wrap_up();
  end
endmodule

// *** bench/dci_dram_model.sv ***
// behavioural dram on the far side of the channel: logs commands and writes, answers reads
`timescale 1ns/1ps

module dci_dram_model (
  input wire logic mem_clk,
  input wire logic cmd_oe,
  input wire logic [1:0] cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [15:0] ma,
  input wire logic [9:0] lp_command_address_bus,
  input wire logic [1:0] odt,
  input wire logic [63:0] dq_out,
  input wire logic dq_oe,
  input wire logic [7:0] dm,
  input wire logic [7:0] dqs_p_out,
  input wire logic [7:0] ecc_check_byte_out,
  input wire logic [63:0] rd_word,
  input wire logic [7:0] rd_chk,
  input wire logic [3:0] rd_lat,
  input wire logic [2:0] rd_delay,
  input wire logic mute,
  output logic [63:0] dq_in,
  output logic [7:0] dqs_p_in,
  output logic [7:0] dqs_n_in,
  output logic [7:0] ecc_check_byte_in,
  output logic ecc_strobe_true_in,
  output logic ecc_strobe_complement_in,
  output logic [2:0] seen_enc,
  output logic [1:0] seen_cs_n,
  output logic [15:0] seen_ma,
  output logic [9:0] seen_lp,
  output logic [63:0] seen_wdata,
  output logic [7:0] seen_wmask,
  output logic [7:0] seen_wchk,
  output logic [1:0] seen_odt,
  output logic [4:0] seen_gap
);
  logic [4:0] rd_cnt;
  logic [4:0] wr_cnt;
  logic [1:0] hold;
  logic last_p;
  logic is_rd;

  // a read is recognised in either command form
  assign is_rd = cmd_oe && ({ras_n, cas_n, we_n} == 3'h5 || lp_command_address_bus[3:0] == 4'h2);
  assign ecc_strobe_true_in = dqs_p_in[0];
  assign ecc_strobe_complement_in = dqs_n_in[0];

  // idle lines start as a quiet differential pair
  initial
  begin
    dq_in = 64'h0;
    dqs_p_in = 8'h00;
    dqs_n_in = 8'hFF;
    ecc_check_byte_in = 8'h00;
    rd_cnt = 5'h0;
    hold = 2'h0;
    wr_cnt = 5'h0;
    last_p = 1'b0;
  end

  // log each command and take write data on the rising true strobe
  always @(posedge mem_clk)
  begin
    if (cmd_oe)
    begin
      seen_enc <= {ras_n, cas_n, we_n};
      seen_cs_n <= cs_n;
      seen_ma <= ma;
      seen_lp <= lp_command_address_bus;
      wr_cnt <= 5'h1;
    end
    else
      wr_cnt <= wr_cnt + 5'h1;
    last_p <= dqs_p_out[0];
    if (dq_oe && dqs_p_out[0] && !last_p)
    begin
      seen_wdata <= dq_out;
      seen_wmask <= dm;
      seen_wchk <= ecc_check_byte_out;
      seen_odt <= odt;
      seen_gap <= wr_cnt;
    end
  end

  // answer reads after the latency plus an optional stall, unless muted
  always @(posedge mem_clk)
  begin
    if (is_rd && !mute)
      rd_cnt <= {1'b0, rd_lat} + {2'h0, rd_delay};
    else if (rd_cnt != 5'h0)
      rd_cnt <= rd_cnt - 5'h1;
    if (rd_cnt == 5'h1)
    begin
      dq_in <= rd_word;
      ecc_check_byte_in <= rd_chk;
      dqs_p_in <= ~dqs_p_in;
      dqs_n_in <= dqs_p_in;
      hold <= 2'h3;
    end
    else if (hold != 2'h0)
    begin
      hold <= hold - 2'h1;
      // released lines flip so stale data can never pass for an answer
      if (hold == 2'h1)
      begin
        dq_in <= ~dq_in;
        ecc_check_byte_in <= ~ecc_check_byte_in;
        dqs_p_in <= ~dqs_p_in;
        dqs_n_in <= ~dqs_n_in;
      end
    end
  end
endmodule

// *** verilog/dci_cfg.svh ***
// constants for the dram channel interface: encodings, limits and field masks
`ifndef DCI_CFG_SVH
`define DCI_CFG_SVH

// latency limits in memory clock cycles
`define DCI_RL_MIN 4'h5
`define DCI_RL_MAX 4'hD
`define DCI_WL_MIN 4'h3
`define DCI_WL_MAX 4'h8
// cycles a read waits for a strobe crossing after the latency expires
`define DCI_RD_WIN 4'h8
// per-channel transfer rate in mega-transfers per second
`define DCI_DATA_RATE_MTS 1600

// ddr3 command encodings as {ras_n, cas_n, we_n}
`define DCI_ENC_NOP 3'h7
`define DCI_ENC_ACT 3'h3
`define DCI_ENC_RD 3'h5
`define DCI_ENC_WR 3'h4
`define DCI_ENC_PRE 3'h2
`define DCI_ENC_REF 3'h1
`define DCI_ENC_MRS 3'h0

// device geometry select and address masks
`define DCI_GEO_2GB 2'h0
`define DCI_GEO_4GB 2'h1
`define DCI_GEO_8GB 2'h2
`define DCI_ROW14_MASK 15'h3FFF
`define DCI_ROW15_MASK 15'h7FFF
`define DCI_COL9_MASK 10'h1FF
`define DCI_COL10_MASK 10'h3FF

`endif

// *** verilog/dci_channel.sv ***
// dram channel interface: user command port on ref_clk, dram pins on mem_clk
//
// Contract
// - mask high marks a write beat unwritten
// - capture data at true/complement strobe crossing
// - read strobe edge-aligned; controller shifts it
// - write strobe crossing centred in data
// - termination on during write transfers
// - one chip select per rank, addressed only
// - one clock pair per rank
// - ddr3 command from ras, cas, we, select
// - clock enables drive power-up, power-down, self-refresh
// - lpddr3 uses clock enables 0 and 2
// - lpddr3 ten-bit command/address bus
// - ecc mode disables channel 1, reuses pins
// - ecc only ddr3, single channel, 64-bit
// - read latency 5 through 13
// - write latency 3 through 8
// - tri-state command bus when no command
// - early self-refresh exit, slow power-down, clock gating
// - lpddr3 row/column widths per density
// - ddr3 2gb x16: 14 row, 10 column
// - lpddr3 up to two ranks per channel
// - 1600 mega-transfers per second per channel
`timescale 1ns/1ps
`include "dci_cfg.svh"

module dci_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mem_clk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_rank,
  input wire logic [2:0] cmd_bank,
  input wire logic [14:0] cmd_row,
  input wire logic [9:0] cmd_col,
  input wire logic [63:0] wr_data,
  input wire logic [7:0] wr_mask,
  input wire logic [7:0] wr_ecc,
  input wire logic wr_ecc_mask,
  input wire logic cfg_lp_mode,
  input wire logic cfg_ecc_en,
  input wire logic [1:0] cfg_geometry,
  input wire logic [3:0] cfg_rd_lat,
  input wire logic [3:0] cfg_wr_lat,
  input wire logic cfg_clk_gate_en,
  input wire logic cfg_slow_pd,
  output logic rd_valid,
  output logic [63:0] rd_data,
  output logic [7:0] rd_ecc,
  output logic rd_timeout,
  output logic ch1_enable,
  output logic [1:0] ck_p,
  output logic [1:0] ck_n,
  output logic [1:0] cs_n,
  output logic [3:0] cke,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [15:0] ma,
  output logic [2:0] ba,
  output logic [9:0] lp_command_address_bus,
  output logic cmd_oe,
  output logic [1:0] odt,
  output logic memory_reset_out_n,
  input wire logic [63:0] dq_in,
  output logic [63:0] dq_out,
  output logic dq_oe,
  output logic [7:0] dm,
  input wire logic [7:0] dqs_p_in,
  input wire logic [7:0] dqs_n_in,
  output logic [7:0] dqs_p_out,
  output logic [7:0] dqs_n_out,
  output logic dqs_oe,
  input wire logic [7:0] ecc_check_byte_in,
  output logic [7:0] ecc_check_byte_out,
  output logic ecc_check_byte_oe,
  output logic ecc_check_byte_mask,
  input wire logic ecc_strobe_true_in,
  input wire logic ecc_strobe_complement_in,
  output logic ecc_strobe_true_out,
  output logic ecc_strobe_complement_out,
  output logic ecc_strobe_oe
);

  // ---------------- ref_clk side: request payload held until ack ----------------
  logic req_tgl_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_s3_r;
  logic ack_evt;
  logic [3:0] q_code_r;
  logic q_rank_r;
  logic [2:0] q_bank_r;
  logic [14:0] q_row_r;
  logic [9:0] q_col_r;
  logic [63:0] q_wdata_r;
  logic [7:0] q_wmask_r;
  logic [7:0] q_wecc_r;
  logic q_wecc_mask_r;
  logic q_lp_r;
  logic q_ecc_r;
  logic [1:0] q_geo_r;
  logic [3:0] q_rl_r;
  logic [3:0] q_wl_r;
  logic q_gate_r;
  logic q_slow_r;
  // link-side result words, stable while the ack toggle crosses
  logic [63:0] m_rdata_r;
  logic [7:0] m_recc_r;
  logic m_rto_r;
  logic ack_tgl_r;

  assign ack_evt = ack_s2_r ^ ack_s3_r;

  // ack toggle synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end
    else
    begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  // accept one command at a time; the payload must not move until the link acks
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_tgl_r <= 1'b0;
      cmd_ready <= 1'b1;
      q_code_r <= 4'h0;
      q_rank_r <= 1'b0;
      q_bank_r <= 3'h0;
      q_row_r <= 15'h0000;
      q_col_r <= 10'h000;
      q_wdata_r <= 64'h0;
      q_wmask_r <= 8'h00;
      q_wecc_r <= 8'h00;
      q_wecc_mask_r <= 1'b0;
      q_lp_r <= 1'b0;
      q_ecc_r <= 1'b0;
      q_geo_r <= 2'h0;
      q_rl_r <= 4'h0;
      q_wl_r <= 4'h0;
      q_gate_r <= 1'b0;
      q_slow_r <= 1'b0;
    end
    else if (cmd_valid && cmd_ready)
    begin
      req_tgl_r <= ~req_tgl_r;
      cmd_ready <= 1'b0;
      q_code_r <= cmd_code;
      q_rank_r <= cmd_rank;
      q_bank_r <= cmd_bank;
      q_row_r <= cmd_row;
      q_col_r <= cmd_col;
      q_wdata_r <= wr_data;
      q_wmask_r <= wr_mask;
      q_wecc_r <= wr_ecc;
      q_wecc_mask_r <= wr_ecc_mask;
      q_lp_r <= cfg_lp_mode;
      q_ecc_r <= cfg_ecc_en && !cfg_lp_mode;
      q_geo_r <= cfg_geometry;
      q_rl_r <= cfg_rd_lat;
      q_wl_r <= cfg_wr_lat;
      q_gate_r <= cfg_clk_gate_en;
      q_slow_r <= cfg_slow_pd;
    end
    else if (ack_evt)
    begin
      cmd_ready <= 1'b1;
    end
  end

  // read results and channel-1 ownership
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= 64'h0;
      rd_ecc <= 8'h00;
      rd_timeout <= 1'b0;
      ch1_enable <= 1'b1;
    end
    else
    begin
      rd_valid <= ack_evt && (q_code_r == dci_pkg::DCI_RD);
      if (ack_evt && (q_code_r == dci_pkg::DCI_RD))
      begin
        rd_data <= m_rdata_r;
        rd_ecc <= m_recc_r;
        rd_timeout <= m_rto_r;
      end
      ch1_enable <= !(cfg_ecc_en && !cfg_lp_mode);
    end
  end

  // ---------------- mem_clk side ----------------
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic req_evt;
  dci_pkg::dci_state_t st_r;
  logic [3:0] lat_cnt_r;
  logic [3:0] lat_seen_r;
  logic [7:0] dqs_p_s1_r;
  logic [7:0] dqs_p_s2_r;
  logic [7:0] dqs_p_s3_r;
  logic [7:0] dqs_n_s1_r;
  logic [7:0] dqs_n_s2_r;
  logic [63:0] dq_s1_r;
  logic [63:0] dq_s2_r;
  logic [7:0] ecc_s1_r;
  logic [7:0] ecc_s2_r;
  logic estb_s1_r;
  logic estb_s2_r;
  logic estbn_s1_r;
  logic estbn_s2_r;
  logic strobe_cross;
  logic is_wr;
  logic is_rd;
  logic [3:0] rl_eff;
  logic [3:0] wl_eff;
  logic [14:0] row_eff;
  logic [9:0] col_eff;
  logic [2:0] enc;
  logic sr_r;
  logic pd_r;
  logic ck_run;

  assign req_evt = req_s2_r ^ req_s3_r;
  assign is_wr = (q_code_r == dci_pkg::DCI_WR);
  assign is_rd = (q_code_r == dci_pkg::DCI_RD);
  // out-of-range latencies are clamped rather than refused
  assign rl_eff = (q_rl_r < `DCI_RL_MIN) ? `DCI_RL_MIN :
                  (q_rl_r > `DCI_RL_MAX) ? `DCI_RL_MAX : q_rl_r;
  assign wl_eff = (q_wl_r < `DCI_WL_MIN) ? `DCI_WL_MIN :
                  (q_wl_r > `DCI_WL_MAX) ? `DCI_WL_MAX : q_wl_r;
  // row and column widths follow device type and density
  assign row_eff = q_row_r & ((q_lp_r && q_geo_r == `DCI_GEO_8GB) ?
                   `DCI_ROW15_MASK : `DCI_ROW14_MASK);
  assign col_eff = q_col_r & ((q_lp_r && q_geo_r == `DCI_GEO_2GB) ?
                   `DCI_COL9_MASK : `DCI_COL10_MASK);
  // the sync stages act as the read strobe shift; byte 0 is the timing reference
  assign strobe_cross = (dqs_p_s2_r[0] != dqs_p_s3_r[0]) &&
                        (dqs_p_s2_r[0] != dqs_n_s2_r[0]);
  // stop flags are latched at entry on this side, so no user-side bit gates the clock
  assign ck_run = !(sr_r || pd_r);

  // command to row/column/write-enable code
  always_comb
  begin
    unique case (q_code_r)
      dci_pkg::DCI_ACT: enc = `DCI_ENC_ACT;
      dci_pkg::DCI_RD: enc = `DCI_ENC_RD;
      dci_pkg::DCI_WR: enc = `DCI_ENC_WR;
      dci_pkg::DCI_PRE: enc = `DCI_ENC_PRE;
      dci_pkg::DCI_REF, dci_pkg::DCI_SRE: enc = `DCI_ENC_REF;
      dci_pkg::DCI_MRS: enc = `DCI_ENC_MRS;
      default: enc = `DCI_ENC_NOP;
    endcase
  end

  // request toggle and pin input synchronisers
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      dqs_p_s1_r <= 8'h00;
      dqs_p_s2_r <= 8'h00;
      dqs_p_s3_r <= 8'h00;
      dqs_n_s1_r <= 8'hFF;
      dqs_n_s2_r <= 8'hFF;
      dq_s1_r <= 64'h0;
      dq_s2_r <= 64'h0;
      ecc_s1_r <= 8'h00;
      ecc_s2_r <= 8'h00;
      estb_s1_r <= 1'b0;
      estb_s2_r <= 1'b0;
      estbn_s1_r <= 1'b1;
      estbn_s2_r <= 1'b1;
    end
    else
    begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      dqs_p_s1_r <= dqs_p_in;
      dqs_p_s2_r <= dqs_p_s1_r;
      dqs_p_s3_r <= dqs_p_s2_r;
      dqs_n_s1_r <= dqs_n_in;
      dqs_n_s2_r <= dqs_n_s1_r;
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      ecc_s1_r <= ecc_check_byte_in;
      ecc_s2_r <= ecc_s1_r;
      estb_s1_r <= ecc_strobe_true_in;
      estb_s2_r <= estb_s1_r;
      estbn_s1_r <= ecc_strobe_complement_in;
      estbn_s2_r <= estbn_s1_r;
    end
  end

  // transfer sequencer
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= dci_pkg::DCI_S_IDLE;
      lat_cnt_r <= 4'h0;
      ack_tgl_r <= 1'b0;
      m_rdata_r <= 64'h0;
      m_recc_r <= 8'h00;
      m_rto_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        dci_pkg::DCI_S_IDLE:
          if (req_evt)
            st_r <= dci_pkg::DCI_S_ISSUE;
        dci_pkg::DCI_S_ISSUE:
        begin
          lat_cnt_r <= is_wr ? wl_eff - 4'h1 : rl_eff - 4'h1;
          if (is_wr)
            st_r <= dci_pkg::DCI_S_WLAT;
          else if (is_rd)
            st_r <= dci_pkg::DCI_S_RLAT;
          else
          begin
            ack_tgl_r <= ~ack_tgl_r;
            st_r <= dci_pkg::DCI_S_IDLE;
          end
        end
        dci_pkg::DCI_S_WLAT:
        begin
          lat_cnt_r <= lat_cnt_r - 4'h1;
          if (lat_cnt_r == 4'h1)
            st_r <= dci_pkg::DCI_S_WDATA;
        end
        dci_pkg::DCI_S_WDATA:
          st_r <= dci_pkg::DCI_S_WSTB;
        dci_pkg::DCI_S_WSTB:
        begin
          ack_tgl_r <= ~ack_tgl_r;
          st_r <= dci_pkg::DCI_S_IDLE;
        end
        dci_pkg::DCI_S_RLAT:
        begin
          lat_cnt_r <= lat_cnt_r - 4'h1;
          if (lat_cnt_r == 4'h1)
          begin
            lat_cnt_r <= `DCI_RD_WIN;
            st_r <= dci_pkg::DCI_S_RCAP;
          end
        end
        dci_pkg::DCI_S_RCAP:
        begin
          lat_cnt_r <= lat_cnt_r - 4'h1;
          // a missing strobe must not hang the user port
          if (strobe_cross || lat_cnt_r == 4'h1)
          begin
            m_rdata_r <= dq_s2_r;
            m_recc_r <= (q_ecc_r && (estb_s2_r != estbn_s2_r)) ? ecc_s2_r : 8'h00;
            m_rto_r <= !strobe_cross;
            ack_tgl_r <= ~ack_tgl_r;
            st_r <= dci_pkg::DCI_S_IDLE;
          end
        end
        default:
          st_r <= dci_pkg::DCI_S_IDLE;
      endcase
    end
  end

  // command pins: driven only in the issue cycle, released otherwise
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_oe <= 1'b0;
      cs_n <= 2'h3;
      {ras_n, cas_n, we_n} <= `DCI_ENC_NOP;
      ma <= 16'h0000;
      ba <= 3'h0;
      lp_command_address_bus <= 10'h000;
    end
    else if (st_r == dci_pkg::DCI_S_ISSUE && q_code_r != dci_pkg::DCI_NOP &&
             q_code_r != dci_pkg::DCI_RSTX)
    begin
      cmd_oe <= 1'b1;
      cs_n <= q_rank_r ? 2'h1 : 2'h2;
      {ras_n, cas_n, we_n} <= q_lp_r ? `DCI_ENC_NOP : enc;
      ma <= (q_code_r == dci_pkg::DCI_ACT) ? {1'b0, row_eff} : {6'h00, col_eff};
      ba <= q_bank_r;
      lp_command_address_bus <= q_lp_r ? {row_eff[2:0], enc, q_code_r} : 10'h000;
    end
    else
    begin
      cmd_oe <= 1'b0;
      cs_n <= 2'h3;
      {ras_n, cas_n, we_n} <= `DCI_ENC_NOP;
    end
  end

  // power state: clock enables, self-refresh and power-down, dram reset
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cke <= 4'h0;
      sr_r <= 1'b0;
      pd_r <= 1'b0;
      memory_reset_out_n <= 1'b0;
    end
    else if (st_r == dci_pkg::DCI_S_ISSUE)
    begin
      unique case (q_code_r)
        dci_pkg::DCI_RSTX: memory_reset_out_n <= 1'b1;
        dci_pkg::DCI_SRE:
        begin
          cke <= 4'h0;
          sr_r <= q_gate_r;
        end
        dci_pkg::DCI_PDE:
        begin
          cke <= 4'h0;
          pd_r <= q_slow_r;
        end
        // exit is taken in any cycle, no settle wait before cke rises
        dci_pkg::DCI_SRX, dci_pkg::DCI_PDX:
        begin
          cke <= q_lp_r ? 4'h5 : 4'hF;
          sr_r <= 1'b0;
          pd_r <= 1'b0;
        end
        default:
          cke <= q_lp_r ? (cke & 4'h5) : cke;
      endcase
    end
  end

  // one clock pair per rank, toggling every link cycle while running
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ck_p <= 2'h0;
      ck_n <= 2'h3;
    end
    else if (ck_run)
    begin
      ck_p <= ~ck_p;
      ck_n <= ck_p;
    end
  end

  // write data path: data launched first, strobe edge a cycle later in its centre
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_oe <= 1'b0;
      dq_out <= 64'h0;
      dm <= 8'h00;
      dqs_oe <= 1'b0;
      dqs_p_out <= 8'h00;
      dqs_n_out <= 8'hFF;
      odt <= 2'h0;
      ecc_check_byte_oe <= 1'b0;
      ecc_check_byte_out <= 8'h00;
      ecc_check_byte_mask <= 1'b0;
      ecc_strobe_oe <= 1'b0;
      ecc_strobe_true_out <= 1'b0;
      ecc_strobe_complement_out <= 1'b1;
    end
    else
    begin
      if (st_r == dci_pkg::DCI_S_ISSUE && is_wr)
        odt <= q_rank_r ? 2'h2 : 2'h1;
      else if (st_r == dci_pkg::DCI_S_WSTB)
        odt <= 2'h0;
      if (st_r == dci_pkg::DCI_S_WLAT && lat_cnt_r == 4'h1)
      begin
        dq_oe <= 1'b1;
        dq_out <= q_wdata_r;
        dm <= q_wmask_r;
        dqs_oe <= 1'b1;
        dqs_p_out <= 8'h00;
        dqs_n_out <= 8'hFF;
        ecc_check_byte_oe <= q_ecc_r;
        ecc_check_byte_out <= q_wecc_r;
        ecc_check_byte_mask <= q_wecc_mask_r;
        ecc_strobe_oe <= q_ecc_r;
        ecc_strobe_true_out <= 1'b0;
        ecc_strobe_complement_out <= 1'b1;
      end
      else if (st_r == dci_pkg::DCI_S_WDATA)
      begin
        dqs_p_out <= 8'hFF;
        dqs_n_out <= 8'h00;
        ecc_strobe_true_out <= 1'b1;
        ecc_strobe_complement_out <= 1'b0;
      end
      else if (st_r == dci_pkg::DCI_S_WSTB)
      begin
        dq_oe <= 1'b0;
        dqs_oe <= 1'b0;
        dm <= 8'h00;
        ecc_check_byte_oe <= 1'b0;
        ecc_strobe_oe <= 1'b0;
        dqs_p_out <= 8'h00;
        dqs_n_out <= 8'hFF;
        ecc_strobe_true_out <= 1'b0;
        ecc_strobe_complement_out <= 1'b1;
      end
    end
  end

  // helper: cycles since the sequencer last passed through the issue state, for a command of any kind
  always_ff @(posedge mem_clk or negedge rst_n)
  begin
    if (!rst_n)
      lat_seen_r <= 4'h0;
    else if (st_r == dci_pkg::DCI_S_ISSUE)
      lat_seen_r <= 4'h0;
    else if (lat_seen_r != 4'hF)
      lat_seen_r <= lat_seen_r + 4'h1;
  end

  default clocking mem_cb @(posedge mem_clk);
  endclocking
  default disable iff (!rst_n);

  write_mask_a: assert property (dq_oe |-> dm == q_wmask_r)
    else $error("write mask differs from requested mask");
  read_latency_a: assert property (
    $rose(st_r == dci_pkg::DCI_S_RCAP) |-> lat_seen_r + 4'h1 == rl_eff)
    else $error("read capture window opened at wrong latency");
  write_latency_a: assert property ($rose(dqs_p_out[0]) |-> lat_seen_r == wl_eff)
    else $error("write strobe launched at wrong latency");
  strobe_centre_a: assert property (
    $rose(dq_oe) |=> dqs_p_out == 8'hFF && $stable(dq_out) ##1 !dq_oe)
    else $error("write strobe not centred in data window");
  odt_write_a: assert property (dq_oe |-> odt != 2'h0)
    else $error("termination off while write data driven");
  single_rank_a: assert property (cs_n != 2'h0 && (cs_n == 2'h3 || cmd_oe))
    else $error("chip select for more than one rank or idle bus");
  cmd_tristate_a: assert property (cmd_oe |=> !cmd_oe)
    else $error("command bus held beyond its command cycle");
  ddr3_read_enc_a: assert property (
    cmd_oe && !q_lp_r && is_rd |-> {ras_n, cas_n, we_n} == `DCI_ENC_RD)
    else $error("ddr3 read encoded wrongly");
  lp_cke_bits_a: assert property (
    q_lp_r && st_r != dci_pkg::DCI_S_ISSUE && st_r != dci_pkg::DCI_S_IDLE
    |-> cke[1] == 1'b0 && cke[3] == 1'b0)
    else $error("unused clock enable bit driven in lpddr3 mode");
  ecc_ddr3_only_a: assert property (ecc_check_byte_oe |-> q_ecc_r && !q_lp_r && dq_oe)
    else $error("check byte driven outside ddr3 ecc write");

endmodule

// *** verilog/dci_pkg.sv ***
// types shared by the dram channel interface
package dci_pkg;

  // commands taken on the user side
  typedef enum logic [3:0] {
    DCI_NOP = 4'h0,
    DCI_ACT = 4'h1,
    DCI_RD = 4'h2,
    DCI_WR = 4'h3,
    DCI_PRE = 4'h4,
    DCI_REF = 4'h5,
    DCI_MRS = 4'h6,
    DCI_SRE = 4'h7,
    DCI_SRX = 4'h8,
    DCI_PDE = 4'h9,
    DCI_PDX = 4'hA,
    DCI_RSTX = 4'hB
  } dci_cmd_t;

  // link-side sequencer states, one-hot
  typedef enum logic [6:0] {
    DCI_S_IDLE = 7'h01,
    DCI_S_ISSUE = 7'h02,
    DCI_S_WLAT = 7'h04,
    DCI_S_WDATA = 7'h08,
    DCI_S_WSTB = 7'h10,
    DCI_S_RLAT = 7'h20,
    DCI_S_RCAP = 7'h40
  } dci_state_t;

endpackage
